// *** logic/tvu_pkg.sv ***
package tvu_pkg;
  // Register byte offsets on the Avalon-MM slave.
  localparam logic [5:0] OFF_TRAP_FLAGS = 6'h00;
  localparam logic [5:0] OFF_VEC_SEG = 6'h04;
  localparam logic [5:0] OFF_CPU_CTRL1 = 6'h08;
  localparam logic [5:0] OFF_STATE = 6'h0C;
  localparam logic [5:0] OFF_INT_CTRL0 = 6'h10;
  localparam logic [5:0] OFF_IRQ_STATUS = 6'h24;
  localparam logic [5:0] OFF_IRQ_MASK = 6'h28;
  // Widths.
  localparam int NUM_A = 4;
  localparam int NUM_B = 8;
  localparam int NUM_FLAGS = 12;
  localparam int NUM_NODES = 5;
  localparam int NUM_EVT = 4;
  // Trap flag field positions: class A in the low nibble, class B above.
  localparam int FLAG_B_LSB = 4;
  // Interrupt control register fields.
  localparam int IC_REQ_BIT = 0;
  localparam int IC_EN_BIT = 1;
  // Interrupt event status bits.
  localparam int EVT_CLASS_A = 0;
  localparam int EVT_CLASS_B = 1;
  localparam int EVT_NODE = 2;
  localparam int EVT_SOFT = 3;
  // Trap numbers.
  localparam logic [6:0] TN_RESET = 7'h00;
  localparam logic [6:0] TN_SR0 = 7'h02;
  localparam logic [6:0] TN_STACK_OVERFLOW_FLAG = 7'h04;
  localparam logic [6:0] TN_STACK_UNDERFLOW_FLAG = 7'h06;
  localparam logic [6:0] TN_SBRK = 7'h08;
  localparam logic [6:0] TN_CLASS_B = 7'h0A;
  localparam logic [6:0] TN_ERU0 = 7'h68;
  localparam logic [6:0] TN_ERU1 = 7'h69;
  localparam logic [6:0] TN_ERU2 = 7'h6A;
  localparam logic [6:0] TN_ERU3 = 7'h6D;
  localparam logic [6:0] TN_EOP = 7'h6F;
  // Reserved hardware slots that must never be generated.
  localparam logic [6:0] TN_RSV_LO = 7'h65;
  localparam logic [6:0] TN_RSV_HI = 7'h67;
  // Reset values.
  localparam logic [7:0] VEC_SEG_RST = 8'h00;
  localparam logic [1:0] SPACING_RST = 2'h0;
  // Service levels.
  localparam logic [1:0] LVL_NONE = 2'h0;
  localparam logic [1:0] LVL_B = 2'h1;
  localparam logic [1:0] LVL_A = 2'h2;
  // Dispatcher states, Gray coded along boot, idle, offer.
  typedef enum logic [1:0] {
    ST_BOOT = 2'b00,
    ST_IDLE = 2'b01,
    ST_OFFER = 2'b11
  } tvu_state_t;
endpackage

// *** logic/tvu_vec_calc.sv ***
`timescale 1ns/1ns
// Forms the full vector address from segment, trap number and spacing.
module tvu_vec_calc (
  // Vector selection.
  input wire logic [6:0] trap_num_i,
  input wire logic [1:0] spacing_i,
  input wire logic [7:0] segment_i,
  // Result.
  output logic [23:0] vec_addr_o
);
  logic [15:0] offset;

  // Spacing code 0 gives 4 bytes per vector, each step doubles it.
  always_comb begin
    offset = 16'({9'h000, trap_num_i} << (5'd2 + {3'h0, spacing_i}));
    vec_addr_o = {segment_i, offset};
  end
endmodule

// *** logic/tvu_avl_slave.sv ***
`timescale 1ns/1ns
// Avalon-MM slave front end: one wait cycle, then completion.
module tvu_avl_slave (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // Avalon-MM request side.
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  output logic avs_waitrequest_o,
  output logic [31:0] avs_readdata_o,
  // Register file side.
  input wire logic [31:0] reg_rdata_i,
  output logic rd_done_o,
  output logic wr_done_o
);
  logic ack_reg;
  logic ack_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  // The first request cycle waits while read data are captured.
  always_comb begin
    ack_next = (avs_read_i | avs_write_i) & ~ack_reg;
    rdata_next = rdata_reg;
    if (avs_read_i && !ack_reg) begin
      rdata_next = reg_rdata_i;
    end
  end

  // Registers the acknowledge and the read data.
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_reg;
  assign avs_readdata_o = rdata_reg;
  assign rd_done_o = avs_read_i & ack_reg;
  assign wr_done_o = avs_write_i & ack_reg;
endmodule

// *** logic/tvu_trap_unit.sv ***
// The Avalon-MM slave port and the address map were left to the implementer.
`timescale 1ns/1ns
// Contract
// - A hardware trap forces a non-maskable branch offer to its vector.
// - Each hardware trap sets its own bit in the trap flag register.
// - A trap waits while a higher-priority trap service is in progress.
// - Hardware trap service blocks standard interrupt node requests.
// - Class A vectors are 0x08, 0x10, 0x18, 0x20, numbers 02 to 08.
// - All class B sources share vector 0x28, number 0A.
// - Class B sources each own a flag bit.
// - Software traps reach any number 00 to 7F at current priority.
// - Vector spacing comes from cpu_control_one; default spacing is 4 bytes.
// - Vector segment comes from vector_segment_register.
// - Reserved slots 0x194 to 0x19C are never generated by hardware.
// - External requests 0 to 2 vector to 0x1A0 to 0x1A8, numbers 68-6A.
// - External request 3 vectors to 0x1B4, number 6D.
// - End of subchannel request vectors to 0x1BC, number 6F.
module tvu_trap_unit (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // Avalon-MM slave.
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Trap and request sources; events are one-cycle pulses, software trap requests are held until ready.
  input wire logic [3:0] class_a_evt_i,
  input wire logic [7:0] class_b_evt_i,
  input wire logic [4:0] node_req_i,
  input wire logic sw_trap_valid_i,
  input wire logic [6:0] sw_trap_num_i,
  output logic sw_trap_ready_o,
  // Program sequencer side.
  output logic vec_valid_o,
  input wire logic vec_ready_i,
  output logic [23:0] vec_addr_o,
  output logic [6:0] vec_num_o,
  input wire logic svc_done_i,
  output logic [1:0] svc_level_o,
  // Interrupt.
  output logic irq_o
);
  ////////////////////////////////////////////////////////////////////////////
  logic [11:0] flags_reg, flags_next;
  logic [7:0] seg_reg, seg_next;
  logic [1:0] spc_reg, spc_next;
  logic [1:0] ic_reg [5], ic_next [5];
  logic [3:0] sts_reg, sts_next, msk_reg, msk_next;
  logic [3:0] apend_reg, apend_next, evt;
  logic [1:0] lvl_reg, lvl_next, prev_reg, prev_next;
  tvu_pkg::tvu_state_t st_reg, st_next;
  logic [6:0] num_reg, num_next, pick_num;
  logic [1:0] cls_reg, cls_next, pick_cls;
  logic [31:0] rdata;
  logic rd_done, wr_done, pick, pick_sw, accept;
  logic bpend_reg, bpend_next, sw_reg, sw_next;
  logic [4:0] node_live;

  // Bus front end.
  tvu_avl_slave u_slave (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i),
    .avs_waitrequest_o(avs_waitrequest_o),
    .avs_readdata_o(avs_readdata_o),
    .reg_rdata_i(rdata),
    .rd_done_o(rd_done),
    .wr_done_o(wr_done)
  );
  // Address formation for the captured trap number.
  tvu_vec_calc u_calc (
    .trap_num_i(num_reg),
    .spacing_i(spc_reg),
    .segment_i(seg_reg),
    .vec_addr_o(vec_addr_o)
  );
  ////////////////////////////////////////////////////////////////////////////
  // Maps a node index to its trap number.
  function automatic logic [6:0] node_num(input int idx);
    case (idx)
      0: node_num = tvu_pkg::TN_ERU0;
      1: node_num = tvu_pkg::TN_ERU1;
      2: node_num = tvu_pkg::TN_ERU2;
      3: node_num = tvu_pkg::TN_ERU3;
      default: node_num = tvu_pkg::TN_EOP;
    endcase
  endfunction
  // Maps a class A index to its trap number.
  function automatic logic [6:0] a_num(input int idx);
    case (idx)
      0: a_num = tvu_pkg::TN_SR0;
      1: a_num = tvu_pkg::TN_STACK_OVERFLOW_FLAG;
      2: a_num = tvu_pkg::TN_STACK_UNDERFLOW_FLAG;
      default: a_num = tvu_pkg::TN_SBRK;
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // Arbitration: class A, then class B, then nodes, then software traps.
  always_comb begin
    pick = 1'b0;
    pick_sw = 1'b0;
    pick_num = tvu_pkg::TN_RESET;
    pick_cls = tvu_pkg::LVL_NONE;
    for (int i = 0; i < tvu_pkg::NUM_NODES; i++) begin
      node_live[i] = ic_reg[i][tvu_pkg::IC_REQ_BIT] & ic_reg[i][tvu_pkg::IC_EN_BIT];
    end
    if (|apend_reg && lvl_reg != tvu_pkg::LVL_A) begin
      pick = 1'b1;
      pick_cls = tvu_pkg::LVL_A;
      for (int i = tvu_pkg::NUM_A - 1; i >= 0; i--) begin
        if (apend_reg[i]) begin
          pick_num = a_num(i);
        end
      end
    end else if (bpend_reg && lvl_reg == tvu_pkg::LVL_NONE) begin
      pick = 1'b1;
      pick_cls = tvu_pkg::LVL_B;
      pick_num = tvu_pkg::TN_CLASS_B;
    end else if (|node_live && lvl_reg == tvu_pkg::LVL_NONE) begin
      pick = 1'b1;
      for (int i = tvu_pkg::NUM_NODES - 1; i >= 0; i--) begin
        if (node_live[i]) begin
          pick_num = node_num(i);
        end
      end
    end else if (sw_trap_valid_i) begin
      pick = 1'b1;
      pick_sw = 1'b1;
      pick_num = sw_trap_num_i;
    end
  end

  assign sw_trap_ready_o = (st_reg == tvu_pkg::ST_IDLE) & pick_sw;
  assign vec_valid_o = (st_reg != tvu_pkg::ST_IDLE);
  assign accept = vec_valid_o & vec_ready_i;
  assign vec_num_o = num_reg;
  assign svc_level_o = lvl_reg;
  assign irq_o = |(sts_reg & msk_reg);
  ////////////////////////////////////////////////////////////////////////////
  // Dispatcher sequencing and service level tracking.
  always_comb begin
    st_next = st_reg;
    num_next = num_reg;
    cls_next = cls_reg;
    lvl_next = lvl_reg;
    prev_next = prev_reg;
    sw_next = sw_reg;
    evt = 4'h0;
    if (svc_done_i) begin
      lvl_next = prev_reg;
      prev_next = tvu_pkg::LVL_NONE;
    end
    case (st_reg)
      tvu_pkg::ST_BOOT: begin
        if (accept) begin
          st_next = tvu_pkg::ST_IDLE;
        end
      end
      tvu_pkg::ST_IDLE: begin
        if (pick) begin
          st_next = tvu_pkg::ST_OFFER;
          num_next = pick_num;
          cls_next = pick_cls;
          sw_next = pick_sw;
        end
      end
      tvu_pkg::ST_OFFER: begin
        if (vec_ready_i) begin
          st_next = tvu_pkg::ST_IDLE;
          if (cls_reg != tvu_pkg::LVL_NONE) begin
            prev_next = lvl_reg;
            lvl_next = cls_reg;
          end
          evt[tvu_pkg::EVT_CLASS_A] = (cls_reg == tvu_pkg::LVL_A);
          evt[tvu_pkg::EVT_CLASS_B] = (cls_reg == tvu_pkg::LVL_B);
          evt[tvu_pkg::EVT_NODE] = (cls_reg == tvu_pkg::LVL_NONE) & ~sw_reg;
          evt[tvu_pkg::EVT_SOFT] = sw_reg;
        end
      end
      default: st_next = tvu_pkg::ST_IDLE;
    endcase
  end
  ////////////////////////////////////////////////////////////////////////////
  // Register reads.
  always_comb begin
    rdata = 32'h0000_0000;
    case (avs_address_i)
      tvu_pkg::OFF_TRAP_FLAGS: rdata = {20'h00000, flags_reg};
      tvu_pkg::OFF_VEC_SEG: rdata = {24'h000000, seg_reg};
      tvu_pkg::OFF_CPU_CTRL1: rdata = {30'h00000000, spc_reg};
      tvu_pkg::OFF_STATE: rdata = {28'h0000000, prev_reg, lvl_reg};
      tvu_pkg::OFF_IRQ_STATUS: rdata = {28'h0000000, sts_reg};
      tvu_pkg::OFF_IRQ_MASK: rdata = {28'h0000000, msk_reg};
      default: begin
        for (int i = 0; i < tvu_pkg::NUM_NODES; i++) begin
          if (avs_address_i == 6'(tvu_pkg::OFF_INT_CTRL0 + 6'(4 * i))) begin
            rdata = {30'h00000000, ic_reg[i]};
          end
        end
      end
    endcase
  end

  // Register writes and hardware updates; hardware sets win over clears.
  always_comb begin
    flags_next = flags_reg;
    seg_next = seg_reg;
    spc_next = spc_reg;
    msk_next = msk_reg;
    sts_next = sts_reg;
    apend_next = apend_reg;
    bpend_next = bpend_reg;
    for (int i = 0; i < tvu_pkg::NUM_NODES; i++) begin
      ic_next[i] = ic_reg[i];
    end
    if (wr_done) begin
      case (avs_address_i)
        tvu_pkg::OFF_TRAP_FLAGS: flags_next = flags_reg & ~avs_writedata_i[11:0];
        tvu_pkg::OFF_VEC_SEG: seg_next = avs_writedata_i[7:0];
        tvu_pkg::OFF_CPU_CTRL1: spc_next = avs_writedata_i[1:0];
        tvu_pkg::OFF_IRQ_MASK: msk_next = avs_writedata_i[3:0];
        default: begin
          for (int i = 0; i < tvu_pkg::NUM_NODES; i++) begin
            if (avs_address_i == 6'(tvu_pkg::OFF_INT_CTRL0 + 6'(4 * i))) begin
              ic_next[i] = avs_writedata_i[1:0];
            end
          end
        end
      endcase
    end
    if (rd_done && avs_address_i == tvu_pkg::OFF_IRQ_STATUS) begin
      sts_next = 4'h0;
    end
    sts_next = sts_next | evt;
    if (accept && st_reg == tvu_pkg::ST_OFFER) begin
      if (cls_reg == tvu_pkg::LVL_A) begin
        for (int i = 0; i < tvu_pkg::NUM_A; i++) begin
          if (a_num(i) == num_reg) begin
            apend_next[i] = 1'b0;
          end
        end
      end
      if (cls_reg == tvu_pkg::LVL_B) begin
        bpend_next = 1'b0;
      end
      for (int i = 0; i < tvu_pkg::NUM_NODES; i++) begin
        if (cls_reg == tvu_pkg::LVL_NONE && !sw_reg && node_num(i) == num_reg) begin
          ic_next[i][tvu_pkg::IC_REQ_BIT] = 1'b0;
        end
      end
    end
    flags_next = flags_next | {class_b_evt_i, class_a_evt_i};
    apend_next = apend_next | class_a_evt_i;
    bpend_next = bpend_next | (|class_b_evt_i);
    for (int i = 0; i < tvu_pkg::NUM_NODES; i++) begin
      ic_next[i][tvu_pkg::IC_REQ_BIT] = ic_next[i][tvu_pkg::IC_REQ_BIT] | node_req_i[i];
    end
  end
  // State registers; reset leaves the reset vector on offer.
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_reg <= tvu_pkg::ST_BOOT;
      num_reg <= tvu_pkg::TN_RESET;
      cls_reg <= tvu_pkg::LVL_NONE;
      lvl_reg <= tvu_pkg::LVL_NONE;
      prev_reg <= tvu_pkg::LVL_NONE;
      flags_reg <= 12'h000;
      seg_reg <= tvu_pkg::VEC_SEG_RST;
      spc_reg <= tvu_pkg::SPACING_RST;
      msk_reg <= 4'h0;
      sts_reg <= 4'h0;
      apend_reg <= 4'h0;
      bpend_reg <= 1'b0;
      sw_reg <= 1'b0;
      for (int i = 0; i < tvu_pkg::NUM_NODES; i++) begin
        ic_reg[i] <= 2'h0;
      end
    end else begin
      st_reg <= st_next;
      num_reg <= num_next;
      cls_reg <= cls_next;
      lvl_reg <= lvl_next;
      prev_reg <= prev_next;
      flags_reg <= flags_next;
      seg_reg <= seg_next;
      spc_reg <= spc_next;
      msk_reg <= msk_next;
      sts_reg <= sts_next;
      apend_reg <= apend_next;
      bpend_reg <= bpend_next;
      sw_reg <= sw_next;
      for (int i = 0; i < tvu_pkg::NUM_NODES; i++) begin
        ic_reg[i] <= ic_next[i];
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Checks on the dispatcher.
  boot_first_a: assert property (@(posedge ref_clk_i) $rose(rst_b_i) |->
    vec_valid_o && vec_num_o == tvu_pkg::TN_RESET && vec_addr_o[15:0] == 16'h0000)
    else $error("Reset vector not offered first.");
  offer_held_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    vec_valid_o && !vec_ready_i |=> vec_valid_o && $stable(vec_num_o))
    else $error("Vector offer dropped before acceptance.");
  flag_set_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    class_a_evt_i[1] |=> flags_reg[1])
    else $error("Trap flag not set by its event.");
  flag_sticky_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    flags_reg[5] && !wr_done |=> flags_reg[5])
    else $error("Trap flag cleared without software.");
  b_vector_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    vec_valid_o && cls_reg == tvu_pkg::LVL_B && spc_reg == 2'h0 |->
    vec_addr_o[15:0] == 16'h0028)
    else $error("Class B vector offset wrong.");
  a_vector_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    class_a_evt_i == 4'h8 && st_reg == tvu_pkg::ST_IDLE && lvl_reg == tvu_pkg::LVL_NONE
    && spc_reg == 2'h0 && !pick |=> ##1 vec_valid_o && vec_addr_o[15:0] == 16'h0020)
    else $error("Software break vector wrong.");
  no_node_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    lvl_reg != tvu_pkg::LVL_NONE && st_reg == tvu_pkg::ST_IDLE |=>
    !(vec_valid_o && cls_reg == tvu_pkg::LVL_NONE && !sw_reg))
    else $error("Interrupt node taken during trap service.");
  no_b_in_a_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    lvl_reg == tvu_pkg::LVL_A && st_reg == tvu_pkg::ST_IDLE |=>
    !(vec_valid_o && cls_reg == tvu_pkg::LVL_B))
    else $error("Class B taken inside class A service.");
  no_reserved_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    vec_valid_o && cls_reg == tvu_pkg::LVL_NONE && !sw_reg |->
    !(vec_num_o >= tvu_pkg::TN_RSV_LO && vec_num_o <= tvu_pkg::TN_RSV_HI))
    else $error("Reserved vector generated.");
  segment_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    vec_valid_o |-> vec_addr_o[23:16] == seg_reg)
    else $error("Vector segment not taken from segment register.");
endmodule

// *** sim/tvu_seq_model.sv ***
`timescale 1ns/1ns
// Behavioural program sequencer that takes offered vectors after a set delay.
module tvu_seq_model (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // Vector offer from the trap unit.
  input wire logic vec_valid_i,
  input wire logic [23:0] vec_addr_i,
  input wire logic [6:0] vec_num_i,
  output logic vec_ready_o,
  output logic svc_done_o,
  // Bench control and report.
  input wire logic [2:0] delay_i,
  input wire logic ret_i,
  output logic taken_o,
  output logic [30:0] taken_vec_o
);
  logic [2:0] wait_cnt;

  ////////////////////////////////////////////////////////////////////////////
  // Ready rises only after the offer has stood for delay_i + 1 cycles, so slow
  // answers are exercised as well as prompt ones.
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      vec_ready_o <= 1'b0;
      svc_done_o <= 1'b0;
      taken_o <= 1'b0;
      taken_vec_o <= 31'h0;
      wait_cnt <= 3'h0;
    end else begin
      taken_o <= 1'b0;
      svc_done_o <= ret_i;
      if (vec_valid_i && vec_ready_o) begin
        taken_o <= 1'b1;
        taken_vec_o <= {vec_num_i, vec_addr_i};
        vec_ready_o <= 1'b0;
        wait_cnt <= 3'h0;
      end else if (vec_valid_i) begin
        if (wait_cnt >= delay_i) begin
          vec_ready_o <= 1'b1;
        end else begin
          wait_cnt <= wait_cnt + 3'h1;
        end
      end
    end
  end
endmodule

// *** sim/tb.sv ***
`timescale 1ns/1ns
// Self-checking bench for the trap vector unit.
module tb;
  logic ref_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [5:0] adr = 6'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [3:0] ev_a = 4'h0;
  logic [7:0] ev_b = 8'h00;
  logic [4:0] ev_n = 5'h00;
  logic sw_v = 1'b0;
  logic [6:0] sw_n = 7'h00;
  logic ret = 1'b0;
  logic [2:0] dly = 3'h0;
  logic [31:0] rdat, d;
  logic wait_req, sw_rdy, vv, vr, sdone, irq, taken;
  logic [23:0] vaddr;
  logic [6:0] vnum;
  logic [1:0] lvl;
  logic [30:0] tvec;
  logic [31:0] exp_q[$];
  logic [6:0] node_tn[5] = '{7'h68, 7'h69, 7'h6A, 7'h6D, 7'h6F};
  int err_total = 0;
  int samples_checked = 0;
  int seed = 32'h9F83247F;
  int seg_m = 0;
  int code_m = 0;
  int flags_m = 0;
  int i;

  // Clock of 40 ns period.
  always #20 ref_clk_i = ~ref_clk_i;

  tvu_trap_unit uut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wait_req), .class_a_evt_i(ev_a), .class_b_evt_i(ev_b),
    .node_req_i(ev_n), .sw_trap_valid_i(sw_v), .sw_trap_num_i(sw_n),
    .sw_trap_ready_o(sw_rdy), .vec_valid_o(vv), .vec_ready_i(vr), .vec_addr_o(vaddr),
    .vec_num_o(vnum), .svc_done_i(sdone), .svc_level_o(lvl), .irq_o(irq));

  tvu_seq_model seq (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .vec_valid_i(vv),
    .vec_addr_i(vaddr), .vec_num_i(vnum), .vec_ready_o(vr), .svc_done_o(sdone),
    .delay_i(dly), .ret_i(ret), .taken_o(taken), .taken_vec_o(tvec));

  ////////////////////////////////////////////////////////////////////////////
  // Compares one value and counts it.
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      err_total++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask

  // Prints the verdict and ends the run.
  task automatic print_verdict();
    if (err_total == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Expected {number, segment, offset} of a vector under the current settings.
  function automatic logic [31:0] vexp(input int num);
    int off;
    off = num * (4 << code_m);
    return {1'b0, 7'(num), 8'(seg_m), 16'(off)};
  endfunction

  // One Avalon-MM cycle held until waitrequest is sampled low.
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] v);
    int k;
    k = 0;
    @(posedge ref_clk_i);
    rd <= ~w;
    wr <= w;
    adr <= a;
    wdat <= v;
    do begin
      @(posedge ref_clk_i);
      k++;
    end while (wait_req !== 1'b0 && k < 50);
    d = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (k >= 50) check(32'h1, 32'h0);
  endtask

  // Reads a register and compares it.
  task automatic rdc(input logic [5:0] a, input logic [31:0] want);
    bus(1'b0, a, 32'h0);
    check(d, want);
  endtask

  // One-cycle source pulses, with a fresh random sequencer delay.
  task automatic fire(input logic [3:0] a, input logic [7:0] b, input logic [4:0] n);
    flags_m = flags_m | int'({b, a});
    @(posedge ref_clk_i);
    ev_a <= a;
    ev_b <= b;
    ev_n <= n;
    dly <= 3'($random(seed));
    @(posedge ref_clk_i);
    ev_a <= 4'h0;
    ev_b <= 8'h00;
    ev_n <= 5'h00;
  endtask

  // Ends the current hardware trap service.
  task automatic svc_end();
    @(posedge ref_clk_i);
    ret <= 1'b1;
    @(posedge ref_clk_i);
    ret <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
  endtask

  // Waits, bounded, until only left vectors remain expected.
  task automatic drain(input int left);
    int k;
    for (k = 0; k < 100 && exp_q.size() > left; k++) @(posedge ref_clk_i);
    check(32'(exp_q.size()), 32'(left));
  endtask

  // Confirms that no vector is offered for six cycles.
  task automatic quiet();
    repeat (6) begin
      @(negedge ref_clk_i);
      check(32'(vv), 32'h0);
    end
  endtask

  // Software trap request held until accepted.
  task automatic swt(input logic [6:0] n);
    int k;
    k = 0;
    exp_q.push_back(vexp(int'(n)));
    @(posedge ref_clk_i);
    sw_v <= 1'b1;
    sw_n <= n;
    do begin
      @(posedge ref_clk_i);
      k++;
    end while (sw_rdy !== 1'b1 && k < 50);
    sw_v <= 1'b0;
    drain(0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Every vector the sequencer takes must be the next one the model expects.
  always @(posedge ref_clk_i) begin
    if (taken === 1'b1) begin
      if (exp_q.size() == 0) check(32'h1, 32'h0);
      else check({1'b0, tvec}, exp_q.pop_front());
    end
  end

  // Watchdog that cuts a hang short.
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    check(32'h1, 32'h0);
    print_verdict();
  end

  // Main sequence.
  initial begin
    exp_q.push_back(32'h0);
    repeat (4) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    drain(0);
    rdc(tvu_pkg::OFF_VEC_SEG, 32'h0);
    rdc(tvu_pkg::OFF_CPU_CTRL1, 32'h0);
    rdc(6'h30, 32'h0);
    bus(1'b1, tvu_pkg::OFF_IRQ_MASK, 32'hF);
    for (i = 0; i < 4; i++) begin
      exp_q.push_back(vexp(2 + 2 * i));
      fire(4'(1 << i), 8'h00, 5'h00);
      drain(0);
      svc_end();
      rdc(tvu_pkg::OFF_TRAP_FLAGS, 32'(flags_m));
    end
    @(negedge ref_clk_i);
    check(32'(irq), 32'h1);
    rdc(tvu_pkg::OFF_IRQ_STATUS, 32'h1);
    @(negedge ref_clk_i);
    check(32'(irq), 32'h0);
    bus(1'b1, tvu_pkg::OFF_IRQ_MASK, 32'h1);
    for (i = 0; i < 8; i++) begin
      exp_q.push_back(vexp(10));
      fire(4'h0, 8'(1 << i), 5'h00);
      drain(0);
      svc_end();
      rdc(tvu_pkg::OFF_TRAP_FLAGS, 32'(flags_m));
    end
    @(negedge ref_clk_i);
    check(32'(irq), 32'h0);
    rdc(tvu_pkg::OFF_IRQ_STATUS, 32'h2);
    for (i = 0; i < 5; i++) begin
      bus(1'b1, tvu_pkg::OFF_INT_CTRL0 + 6'(4 * i), 32'h2);
      exp_q.push_back(vexp(int'(node_tn[i])));
      fire(4'h0, 8'h00, 5'(1 << i));
      drain(0);
    end
    exp_q.push_back(vexp(2));
    fire(4'h1, 8'h00, 5'h00);
    drain(0);
    exp_q.push_back(vexp(4));
    exp_q.push_back(vexp(10));
    exp_q.push_back(vexp(104));
    fire(4'h2, 8'h02, 5'h01);
    quiet();
    svc_end();
    drain(2);
    check(32'(lvl), 32'h2);
    svc_end();
    drain(1);
    check(32'(lvl), 32'h1);
    quiet();
    svc_end();
    drain(0);
    check(32'(lvl), 32'h0);
    rdc(tvu_pkg::OFF_TRAP_FLAGS, 32'(flags_m));
    bus(1'b1, tvu_pkg::OFF_TRAP_FLAGS, 32'hFFF);
    flags_m = 0;
    rdc(tvu_pkg::OFF_TRAP_FLAGS, 32'h0);
    for (i = 0; i < 4; i++) begin
      seg_m = $random(seed) & 255;
      code_m = i;
      bus(1'b1, tvu_pkg::OFF_VEC_SEG, 32'(seg_m));
      bus(1'b1, tvu_pkg::OFF_CPU_CTRL1, 32'(i));
      swt((i == 3) ? 7'h7F : 7'($random(seed)));
    end
    exp_q.push_back(vexp(10));
    fire(4'h0, 8'h10, 5'h00);
    drain(0);
    svc_end();
    rdc(tvu_pkg::OFF_IRQ_STATUS, 32'hF);
    seg_m = 0;
    code_m = 0;
    exp_q.push_back(32'h0);
    @(posedge ref_clk_i);
    rst_b_i <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    drain(0);
    rdc(tvu_pkg::OFF_VEC_SEG, 32'h0);
    print_verdict();
  end
endmodule
